// file: core/data_valid_field_flags.sv
// Data-valid and first-field status pin generator for a data-line decoder.
// Behaviour
// RULE1: The active-low data-valid output goes low in the line where valid data of the mode arrives.
// RULE2: In line-16 label mode the data-valid output returns high at the start of line 16.
// RULE3: In the other modes the data-valid output returns high at the start of the next field.
// RULE4: The field flag goes high at the start of the first field and low at the second.
// RULE5: With the test pin high both outputs follow the address-select pin.
// RULE6: Only the selected mode's set and release apply, and the output idles high.
`timescale 1ns/100ps
`default_nettype none

module data_valid_field_flags (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // Mode selection and video events from on-chip logic
    input wire flags_pkg::rx_mode_t rx_mode,
    input wire flags_pkg::video_events_t events,
    // Test pins
    input wire logic test_input_pin,
    input wire logic address_select_pin,
    // Status pins
    output logic data_valid_low_out,
    output logic first_field_flag_out
);

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic test_sync;
    logic addr_sync;

    pin_sync test_sync_u (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin_in(test_input_pin),
        .level_out(test_sync)
    );

    pin_sync addr_sync_u (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin_in(address_select_pin),
        .level_out(addr_sync)
    );

    // -------------------------------------------------------------------
    // Data-valid state
    // -------------------------------------------------------------------
    logic dav_reg;
    logic dav_next;
    logic set_valid;
    logic release_valid;

    always_comb begin
        set_valid = 1'b0;
        release_valid = 1'b0;
        case (rx_mode) // [RULE6]
            flags_pkg::MODE_LINE16: begin
                set_valid = events.valid_line16; // [RULE1]
                release_valid = events.line16_start; // [RULE2]
            end
            flags_pkg::MODE_PKT2: begin
                set_valid = events.valid_pkt2; // [RULE1]
                release_valid = events.field_start; // [RULE3]
            end
            flags_pkg::MODE_PKT1: begin
                set_valid = events.valid_pkt1; // [RULE1]
                release_valid = events.field_start; // [RULE3]
            end
            flags_pkg::MODE_HEADER: begin
                set_valid = events.valid_header; // [RULE1]
                release_valid = events.field_start; // [RULE3]
            end
            default: begin
                set_valid = 1'b0;
                release_valid = 1'b1;
            end
        endcase
    end

    // A fresh valid line wins over a release in the same cycle, so no data is hidden.
    always_comb begin
        dav_next = dav_reg;
        if (set_valid) begin
            dav_next = 1'b0; // [RULE1]
        end else if (release_valid) begin
            dav_next = 1'b1; // [RULE2] [RULE3]
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dav_reg <= flags_pkg::DAV_RESET;
        end else if (clk_en) begin
            dav_reg <= dav_next;
        end
    end

    // -------------------------------------------------------------------
    // Field flag state
    // -------------------------------------------------------------------
    logic field_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            field_reg <= flags_pkg::FIELD_RESET;
        end else if (clk_en && events.field_start) begin
            field_reg <= events.first_field; // [RULE4]
        end
    end

    // -------------------------------------------------------------------
    // Output stage
    // -------------------------------------------------------------------
    // Test mode is applied at the output flops so the pins stay registered.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            data_valid_low_out <= flags_pkg::DAV_RESET;
            first_field_flag_out <= flags_pkg::FIELD_RESET;
        end else if (clk_en) begin
            if (test_sync) begin
                data_valid_low_out <= addr_sync; // [RULE5]
                first_field_flag_out <= addr_sync; // [RULE5]
            end else begin
                data_valid_low_out <= dav_next;
                first_field_flag_out <= events.field_start ? events.first_field : field_reg;
            end
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence valid_seen_s;
        clk_en && !test_sync && set_valid;
    endsequence

    property valid_drives_low_p;
        @(posedge clock) disable iff (!arst_n)
        valid_seen_s |=> !data_valid_low_out;
    endproperty

    valid_goes_low_a: assert property (valid_drives_low_p) // [RULE1]
        else $error("data valid did not go low after valid line");

    line16_release_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE2]
        clk_en && !test_sync && rx_mode == flags_pkg::MODE_LINE16
        && events.line16_start && !events.valid_line16 |=> data_valid_low_out)
        else $error("data valid not released at line 16");

    field_release_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE3]
        clk_en && !test_sync && rx_mode != flags_pkg::MODE_LINE16 && !set_valid
        && events.field_start |=> data_valid_low_out)
        else $error("data valid not released at field start");

    field_flag_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE4]
        clk_en && !test_sync && events.field_start
        |=> first_field_flag_out == $past(events.first_field))
        else $error("field flag wrong at field start");

    test_mirror_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE5]
        clk_en && test_sync |=> data_valid_low_out == $past(addr_sync)
        && first_field_flag_out == $past(addr_sync))
        else $error("outputs do not follow address select in test mode");

    idle_high_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE6]
        clk_en && !test_sync && !set_valid && dav_reg |=> data_valid_low_out)
        else $error("data valid fell without a valid line");

endmodule // data_valid_field_flags

`default_nettype wire

// file: core/pin_sync.sv
// Two-stage synchroniser for one asynchronous pin.
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // Pin and synchronised level
    input wire logic pin_in,
    output logic level_out
);

    logic meta_reg;

    // Only the second stage reads the first.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b0;
            level_out <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= pin_in;
            level_out <= meta_reg;
        end
    end

endmodule // pin_sync

`default_nettype wire

// file: include/flags_pkg.sv
// Package of types and constants for the data-valid and field flag block.
package flags_pkg;

    // -------------------------------------------------------------------
    // Reception modes
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_LINE16  = 4'b0001,
        MODE_PKT2    = 4'b0010,
        MODE_PKT1    = 4'b0100,
        MODE_HEADER  = 4'b1000
    } rx_mode_t;

    // -------------------------------------------------------------------
    // Timing events from the line and field logic, one-cycle pulses
    // -------------------------------------------------------------------
    typedef struct packed {
        logic field_start;
        logic first_field;
        logic line16_start;
        logic valid_line16;
        logic valid_pkt2;
        logic valid_pkt1;
        logic valid_header;
    } video_events_t;

    // -------------------------------------------------------------------
    // Reset values and synchroniser depth
    // -------------------------------------------------------------------
    localparam logic DAV_RESET = 1'b1;
    localparam logic FIELD_RESET = 1'b0;
    localparam int SYNC_STAGES = 2;

endpackage : flags_pkg

// file: tb/mcu_monitor.sv
// Behavioural model of the host controller that watches the data-valid pin.
`timescale 1ns/100ps
`default_nettype none

module mcu_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Status pins
    input wire logic data_valid_low_out,
    // Count of data arrivals seen
    output logic [7:0] valid_count
);
    logic dv_reg;

    // The host only reacts to a falling edge, as it would poll for fresh data.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dv_reg <= 1'b1;
            valid_count <= 8'h00;
        end else begin
            dv_reg <= data_valid_low_out;
            if (dv_reg && !data_valid_low_out) begin
                valid_count <= valid_count + 8'h01;
            end
        end
    end
endmodule // mcu_monitor

`default_nettype wire

// file: tb/test_data_valid_field_flags.sv
// Self-checking testbench for the data-valid and field flag block.
`timescale 1ns/100ps
`default_nettype none

module test_data_valid_field_flags;
    logic clock, arst_n, clk_en, test_input_pin, address_select_pin;
    logic data_valid_low_out, first_field_flag_out;
    flags_pkg::rx_mode_t rx_mode;
    flags_pkg::video_events_t ev;
    logic [7:0] valid_count;
    logic [1:0] exp_q[$];
    logic [1:0] exp;
    logic [6:0] vb;
    logic a;
    int fail_count = 0;
    int check_count = 0;

    data_valid_field_flags dut_u (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
        .rx_mode(rx_mode), .events(ev), .test_input_pin(test_input_pin),
        .address_select_pin(address_select_pin), .data_valid_low_out(data_valid_low_out),
        .first_field_flag_out(first_field_flag_out));
    mcu_monitor host_u (.clock(clock), .arst_n(arst_n),
        .data_valid_low_out(data_valid_low_out), .valid_count(valid_count));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // -------------------------------------------------------------------
    // Driver notes the expected pins, the monitor compares on the next low phase.
    // -------------------------------------------------------------------
    task automatic step(input logic [6:0] v, input logic [1:0] e);
        @(posedge clock);
        ev <= flags_pkg::video_events_t'(v);
        @(posedge clock);
        ev <= flags_pkg::video_events_t'(7'h00);
        exp_q.push_back(e);
    endtask

    always @(negedge clock) begin
        if (exp_q.size() > 0) begin
            exp = exp_q.pop_front();
            check_count++;
            if ({data_valid_low_out, first_field_flag_out} !== exp) begin
                fail_count++;
                $display("MISMATCH %0t pins %b%b expected %b", $time, data_valid_low_out,
                    first_field_flag_out, exp);
            end
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        test_input_pin = 1'b0;
        address_select_pin = 1'b0;
        rx_mode = flags_pkg::MODE_LINE16;
        ev = flags_pkg::video_events_t'(7'h00);
        void'($urandom(65533));
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        step(7'h00, 2'b10);
        for (int k = 0; k < 4; k++) begin
            rx_mode <= flags_pkg::rx_mode_t'(4'h1 << k);
            vb = 7'h01 << (3 - k);
            step(7'h60, 2'b11);
            step(7'h01 << (3 - ((k + 1) % 4)), 2'b11);
            step(vb, 2'b01);
            step(7'h10, (k == 0) ? 2'b11 : 2'b01);
            if (k != 0) step(7'h40 | vb, 2'b00);
            step(7'h40, 2'b10);
        end
        clk_en <= 1'b0;
        step(7'h61, 2'b10);
        clk_en <= 1'b1;
        rx_mode <= flags_pkg::rx_mode_t'(4'h0);
        step(7'h0f, 2'b10);
        @(negedge clock);
        check_count++;
        if (valid_count !== 8'h04) begin
            fail_count++;
            $display("MISMATCH %0t host saw %0d arrivals", $time, valid_count);
        end
        @(posedge clock);
        test_input_pin <= 1'b1;
        // The first two samples force both levels so a stuck mirror cannot hide.
        for (int i = 0; i < 8; i++) begin
            a = (i < 2) ? 1'(i) : 1'($urandom);
            @(posedge clock);
            address_select_pin <= a;
            repeat (4) @(posedge clock);
            exp_q.push_back({a, a});
        end
        test_input_pin <= 1'b0;
        repeat (6) @(posedge clock);
        step(7'h00, 2'b10);
        // Let the monitor take the last note before the verdict is drawn.
        repeat (2) @(negedge clock);
        check_count++;
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("MISMATCH %0t %0d expected results never compared", $time, exp_q.size());
        end
        tally_and_finish();
    end
endmodule // test_data_valid_field_flags

`default_nettype wire
